// File: mdu_core.sv
//
// Functional notes
// - extensions send motion to main external input
// - only main or single unit drives actuator, off-brightness
// - twilight per unit, central, or disabled
// - main accepts external motion, twilight dependent
// - extension reports motion, never drives actuator
// - main deactivates extension twilight while lit
// - extension repeats motion at cycle time
// - extension delay defaults six seconds
// - retrigger sends no extra motion telegram
// - extension ignores external manual motion
// - three modes: full, semi one, two
// - external motion telegram gives motion impulse
// - manual on starts detection and delay
// - manual off ends detection, back idle
// - disable forces action until released
// - semi one ignores motion until manual on
// - semi one needs new on after end
// - semi two: no delay, manual off ends
// - semi two refused in light-control application
`timescale 1ns/100ps
`include "mdu_cfg.svh"

module mdu_core
	import mdu_pkg::*;
#(
	parameter int CLK_HZ = `MDU_CLK_HZ,
	parameter int TICK_CYCLES = (CLK_HZ / `MDU_MS_PER_S) * `MDU_TICK_MS,
	parameter int CYCLE_MS = `MDU_EXT_CYCLE_MS,
	parameter int EXT_DELAY_MS = `MDU_EXT_DELAY_MS,
	parameter int STD_DELAY_MS = `MDU_STD_DELAY_MS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// configuration
	input wire mdu_cfg_t cfg,
	input wire logic [15:0] extra_delay_ms,
	// sensor
	input wire logic pir_motion,
	input wire logic dark,
	input wire logic bright_off,
	// bus telegrams
	input wire mdu_tel_t tel,
	input wire logic disable_in,
	// outputs
	output logic start_tel,
	output logic end_tel,
	output logic actuator_on,
	output logic motion_tel,
	output logic tw_deact_out,
	output logic forced,
	output logic detecting
);
	localparam int CW = 32;
	localparam int NTEL = $bits(mdu_tel_t);

	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	// every timer reloads to at least one tick; zero would never expire
	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("mdu_core: tick length below one cycle");
	end
	if (CYCLE_MS < 1) begin : g_bad_cycle
		$error("mdu_core: cycle time below one tick");
	end
	if (EXT_DELAY_MS < 1) begin : g_bad_ext
		$error("mdu_core: extension delay below one tick");
	end
	if (STD_DELAY_MS < 1) begin : g_bad_std
		$error("mdu_core: standard delay below one tick");
	end
	// the main delay adds a 16-bit extra on top; keep headroom in the counters
	if (STD_DELAY_MS > `MDU_MAX_STD_MS) begin : g_bad_range
		$error("mdu_core: standard delay too long for the counters");
	end

	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	function automatic logic is_ext(input mdu_role_t r);
		is_ext = (r == `MDU_ROLE_EXT);
	endfunction

	function automatic logic is_main(input mdu_role_t r);
		is_main = (r == `MDU_ROLE_MAIN);
	endfunction

	function automatic logic is_semi1(input mdu_mode_t m);
		is_semi1 = (m == `MDU_MODE_SEMI1);
	endfunction

	function automatic logic is_semi2(input mdu_mode_t m);
		is_semi2 = (m == `MDU_MODE_SEMI2);
	endfunction

	// semi two refused
	// light control owns the switch-off, so semi two falls back to full
	function automatic mdu_mode_t eff_mode(input mdu_mode_t m, input logic app);
		eff_mode = (is_semi2(m) && app) ? mdu_mode_t'(`MDU_MODE_FULL) : m;
	endfunction

	// ----------------------------------------
	// millisecond tick
	// ----------------------------------------
	logic [CW-1:0] pre_r;
	logic tick_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pre_r <= '0;
			tick_r <= 1'b0;
		end else if (pre_r == CW'(TICK_CYCLES - 1)) begin
			pre_r <= '0;
			tick_r <= 1'b1;
		end else begin
			pre_r <= pre_r + CW'(1);
			tick_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// role and mode
	// ----------------------------------------
	logic ext_role, main_role, semi1_now, semi2_now;
	mdu_mode_t mode_eff;
	assign mode_eff = eff_mode(cfg.mode, cfg.light_ctrl_app);
	assign ext_role = is_ext(cfg.role);
	assign main_role = is_main(cfg.role);
	assign semi1_now = is_semi1(mode_eff);
	assign semi2_now = is_semi2(mode_eff);

	// ----------------------------------------
	// telegram gating
	// ----------------------------------------
	logic [NTEL-1:0] tel_g;
	mdu_tel_t tel_q;
	// extension refuses manual
	// an extension listens to the deactivation object only; the rest is main-unit input
	for (genvar gi = 0; gi < NTEL; gi++) begin : g_tel
		if (gi == `MDU_TEL_DEACT_BIT) begin : g_deact
			assign tel_g[gi] = tel[gi] && ext_role;
		end else begin : g_main
			assign tel_g[gi] = tel[gi] && !ext_role;
		end
	end
	assign tel_q = tel_g;

	// ----------------------------------------
	// qualification
	// ----------------------------------------
	logic tw_used, lit_ok, ext_q, motion_q, man_on, man_off, retrig;
	assign tw_used = (cfg.twilight != `MDU_TW_OFF) && !tel_q.tw_deact;
	assign lit_ok = !tw_used || dark;
	assign ext_q = tel_q.ext_motion;
	assign motion_q = (pir_motion || ext_q) && lit_ok;
	assign man_on = tel_q.manual_on;
	assign man_off = tel_q.manual_off;
	// central switch-off brightness
	// only a main or single unit weighs switch-off; an extension keeps retriggering
	assign retrig = (pir_motion || ext_q || man_on) && (ext_role || !bright_off);

	// ----------------------------------------
	// transitions
	// ----------------------------------------
	mdu_state_t state_r;
	logic [CW-1:0] delay_r, cyc_r, delay_ms;
	logic timed_out, go_start, go_end;
	assign delay_ms = ext_role ? CW'(EXT_DELAY_MS) : CW'(STD_DELAY_MS) + CW'(extra_delay_ms);
	assign timed_out = tick_r && (delay_r == CW'(1));
	assign go_start = !disable_in
		&& (((state_r == MDU_IDLE) && !semi1_now && (man_on || motion_q))
		|| ((state_r == MDU_WAIT_ON) && man_on));
	assign go_end = !disable_in && (state_r == MDU_ACTIVE)
		&& (man_off || (!semi2_now && timed_out));

	// ----------------------------------------
	// detection state
	// ----------------------------------------
	// disable forces lock
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= MDU_IDLE;
		end else if (disable_in) begin
			state_r <= MDU_LOCKED;
		end else begin
			unique case (state_r)
			MDU_LOCKED: begin
				state_r <= semi1_now ? MDU_WAIT_ON : MDU_IDLE;
			end
			MDU_WAIT_ON: begin
				if (go_start) begin
					state_r <= MDU_ACTIVE;
				end else if (!semi1_now) begin
					state_r <= MDU_IDLE;
				end
			end
			MDU_IDLE: begin
				if (semi1_now) begin
					state_r <= MDU_WAIT_ON;
				end else if (go_start) begin
					state_r <= MDU_ACTIVE;
				end
			end
			MDU_ACTIVE: begin
				if (go_end) begin
					state_r <= semi1_now ? MDU_WAIT_ON : MDU_IDLE;
				end
			end
			endcase
		end
	end

	// ----------------------------------------
	// transmission delay
	// ----------------------------------------
	// a retrigger wins over a tick decrement in the same cycle, but a retrigger on the expiring tick still ends the delay through go_end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			delay_r <= '0;
		end else if (disable_in || go_end) begin
			delay_r <= '0;
		end else if (go_start) begin
			delay_r <= semi2_now ? '0 : delay_ms;
		end else if ((state_r == MDU_ACTIVE) && !semi2_now) begin
			if (retrig) begin
				delay_r <= delay_ms;
			end else if (tick_r) begin
				delay_r <= delay_r - CW'(1);
			end
		end
	end

	// ----------------------------------------
	// start and end telegrams
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			start_tel <= 1'b0;
			end_tel <= 1'b0;
		end else begin
			start_tel <= go_start;
			end_tel <= go_end;
		end
	end

	// no start or end telegram on disable; the forced action stands instead
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			detecting <= 1'b0;
		end else if (disable_in || go_end) begin
			detecting <= 1'b0;
		end else if (go_start) begin
			detecting <= 1'b1;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// forced action
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			forced <= 1'b0;
		end else begin
			forced <= disable_in;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			actuator_on <= 1'b0;
		end else begin
			actuator_on <= !ext_role && (disable_in || detecting);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tw_deact_out <= 1'b0;
		end else begin
			tw_deact_out <= main_role && (disable_in || detecting);
		end
	end

	// ----------------------------------------
	// extension motion telegrams
	// ----------------------------------------
	// cyclic motion telegram
	// retrigger sends nothing
	// a retrigger only reloads the delay, so no additional telegram goes out
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cyc_r <= '0;
			motion_tel <= 1'b0;
		end else begin
			motion_tel <= 1'b0;
			if (ext_role && start_tel) begin
				motion_tel <= 1'b1;
				cyc_r <= CW'(CYCLE_MS);
			end else if (ext_role && detecting && tick_r) begin
				if (cyc_r <= CW'(1)) begin
					motion_tel <= 1'b1;
					cyc_r <= CW'(CYCLE_MS);
				end else begin
					cyc_r <= cyc_r - CW'(1);
				end
			end else if (!detecting) begin
				cyc_r <= '0;
			end
		end
	end
endmodule // mdu_core

// File: mdu_cfg.svh
`ifndef MDU_CFG_SVH
`define MDU_CFG_SVH
// ----------------------------------------
// timing figures, in milliseconds; clock rate in hertz
// ----------------------------------------
`define MDU_CLK_HZ 40000000
`define MDU_EXT_CYCLE_MS 9000
`define MDU_EXT_DELAY_MS 6000
`define MDU_STD_DELAY_MS 10000
`define MDU_TICK_MS 1
`define MDU_MS_PER_S 1000
`define MDU_MAX_STD_MS 1000000
// ----------------------------------------
// field codes
// ----------------------------------------
`define MDU_ROLE_SINGLE 2'h0
`define MDU_ROLE_MAIN 2'h1
`define MDU_ROLE_EXT 2'h2
`define MDU_MODE_FULL 2'h0
`define MDU_MODE_SEMI1 2'h1
`define MDU_MODE_SEMI2 2'h2
`define MDU_TW_OFF 2'h0
`define MDU_TW_LOCAL 2'h1
`define MDU_TW_CENTRAL 2'h2
`define MDU_TEL_DEACT_BIT 0
`endif

// File: mdu_pkg.sv
package mdu_pkg;
	typedef logic [1:0] mdu_role_t;
	typedef logic [1:0] mdu_mode_t;
	typedef logic [1:0] mdu_tw_t;
	// static configuration bundle
	typedef struct packed {
		mdu_role_t role;
		mdu_mode_t mode;
		mdu_tw_t twilight;
		logic light_ctrl_app;
	} mdu_cfg_t;
	// one-bit telegram inputs from the bus
	typedef struct packed {
		logic ext_motion;
		logic manual_on;
		logic manual_off;
		logic tw_deact;
	} mdu_tel_t;
	typedef enum logic [1:0] {
		MDU_IDLE = 2'b00,
		MDU_ACTIVE = 2'b01,
		MDU_LOCKED = 2'b11,
		MDU_WAIT_ON = 2'b10
	} mdu_state_t;
endpackage

// File: mdu_core_monitor.sv
`timescale 1ns/100ps
`include "mdu_cfg.svh"
// ----------------
// port checker
// ----------------
module mdu_core_monitor
	import mdu_pkg::*;
(
	// clock and inputs
	input wire logic core_clk,
	input wire logic rst,
	input wire mdu_cfg_t cfg,
	input wire mdu_tel_t tel,
	input wire logic disable_in,
	// outputs
	input wire logic start_tel,
	input wire logic end_tel,
	input wire logic actuator_on,
	input wire logic motion_tel,
	input wire logic forced,
	input wire logic detecting
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_ext; cfg.role == `MDU_ROLE_EXT |-> !actuator_on; endproperty
	a_ext: assert property (p_ext) else $error("actuator on in extension");
	property p_st; start_tel |-> detecting; endproperty
	a_st: assert property (p_st) else $error("start without detection");
	property p_lit; $rose(detecting) && cfg.role != `MDU_ROLE_EXT |=> actuator_on; endproperty
	a_lit: assert property (p_lit) else $error("actuator late");
	property p_end; end_tel |-> !detecting; endproperty
	a_end: assert property (p_end) else $error("end while detecting");
	property p_s2; end_tel && cfg.mode == `MDU_MODE_SEMI2 && !cfg.light_ctrl_app
		|-> $past(tel.manual_off); endproperty
	a_s2: assert property (p_s2) else $error("auto end in semi two");
	property p_frc; disable_in [*3] ##0 cfg.role != `MDU_ROLE_EXT |-> forced && actuator_on;
	endproperty
	a_frc: assert property (p_frc) else $error("forced action missing");
	property p_s1; cfg.mode == `MDU_MODE_SEMI1 && !detecting && !forced && !disable_in
		&& !tel.manual_on |=> !start_tel; endproperty
	a_s1: assert property (p_s1) else $error("start without manual on");
	property p_rt; motion_tel |=> !motion_tel [*8]; endproperty
	a_rt: assert property (p_rt) else $error("motion telegram too soon");
	c_st: cover property (start_tel);
	c_end: cover property (end_tel);
	c_mt: cover property (motion_tel);
endmodule // mdu_core_monitor
bind mdu_core mdu_core_monitor i_mon (.core_clk, .rst, .cfg, .tel, .disable_in, .start_tel,
	.end_tel, .actuator_on, .motion_tel, .forced, .detecting);

// File: mdu_peer.sv
`timescale 1ns/100ps
// ----------------
// peer units and push-buttons
// ----------------
module mdu_peer
	import mdu_pkg::*;
(
	// bus side
	input wire logic core_clk,
	output mdu_tel_t tel
);
	initial begin
		tel = '0;
	end
	task send(input int k);
		@(negedge core_clk);
		tel[k] = 1'b1;
		@(negedge core_clk);
		tel[k] = 1'b0;
	endtask
	task lvl(input logic v);
		@(negedge core_clk);
		tel.tw_deact = v;
	endtask
endmodule // mdu_peer

// File: tb_top.sv
`timescale 1ns/100ps
`define C(n, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
	$display("Error %s exp %h got %h", n, e, s); end end
// ----------------
// bench
// ----------------
module tb_top;
	import mdu_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	mdu_cfg_t cfg = 7'h20;
	logic pir = 1'b0;
	logic dark = 1'b1;
	logic dis = 1'b0;
	logic [15:0] xd = 16'h0000;
	logic bo = 1'b0;
	logic td;
	mdu_tel_t tel;
	logic st, en, act, mt, fo, det;
	int n_errors = 0;
	int checks = 0;
	bit seen;
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	mdu_peer i_peer (.core_clk(core_clk), .tel(tel));
	// short ticks keep delays to tens of cycles
	mdu_core #(.TICK_CYCLES(4), .CYCLE_MS(3), .EXT_DELAY_MS(2), .STD_DELAY_MS(5)) i_dut (
		.core_clk(core_clk), .rst(rst), .cfg(cfg), .extra_delay_ms(xd),
		.pir_motion(pir), .dark(dark), .bright_off(bo), .tel(tel), .disable_in(dis),
		.start_tel(st), .end_tel(en), .actuator_on(act), .motion_tel(mt),
		.tw_deact_out(td), .forced(fo), .detecting(det));
	task rs(input mdu_cfg_t c);
		@(negedge core_clk);
		rst = 1'b1;
		cfg = c;
		repeat (3) @(negedge core_clk);
		rst = 1'b0;
	endtask
	task p;
		@(negedge core_clk);
		pir = 1'b1;
		@(negedge core_clk);
		pir = 1'b0;
	endtask
	task wn(input int n);
		seen = 1'b0;
		repeat (n) begin
			@(negedge core_clk);
			if (en === 1'b1) seen = 1'b1;
		end
	endtask
	task we;
		wn(60);
	endtask
	task test_done;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		test_done;
	end
	initial begin
		rs(7'h20);
		p; `C("start", 1'b1, st)
		@(negedge core_clk); `C("act", 1'b1, act)
		`C("deact", 1'b1, td)
		we; `C("end", 1'b1, seen)
		i_peer.send(3); `C("ext", 1'b1, st)
		i_peer.send(1); `C("off", 1'b1, en)
		p; `C("again", 1'b1, st)
		we;
		i_peer.send(2); `C("on", 1'b1, st)
		we;
		rs(7'h22);
		dark = 1'b0;
		p; `C("bright", 1'b0, st)
		dark = 1'b1;
		p; `C("dark", 1'b1, st)
		we;
		rs(7'h28);
		p; `C("s1 pir", 1'b0, st)
		i_peer.send(3); `C("s1 ext", 1'b0, st)
		i_peer.send(2); `C("s1 on", 1'b1, st)
		we; `C("s1 end", 1'b1, seen)
		p; `C("s1 rearm", 1'b0, st)
		rs(7'h30);
		p; `C("s2 start", 1'b1, st)
		we; `C("s2 hold", 1'b0, seen)
		i_peer.send(1); `C("s2 off", 1'b1, en)
		rs(7'h31);
		p;
		we; `C("app end", 1'b1, seen)
		rs(7'h40);
		i_peer.send(2); `C("ext on", 1'b0, st)
		p;
		@(negedge core_clk); `C("mt", 1'b1, mt)
		we; `C("ext end", 1'b1, seen)
		rs(7'h20);
		@(negedge core_clk);
		dis = 1'b1;
		repeat (3) @(negedge core_clk);
		`C("forced", 1'b1, fo & act)
		p; `C("dis pir", 1'b0, st)
		dis = 1'b0;
		repeat (3) @(negedge core_clk);
		p; `C("resume", 1'b1, st)
		we;
		xd = 16'h000a;
		rs(7'h20);
		p;
		wn(40); `C("extra early", 1'b0, seen)
		we; `C("extra end", 1'b1, seen)
		xd = 16'h0000;
		rs(7'h20);
		p;
		repeat (11) @(negedge core_clk);
		bo = 1'b1;
		p; bo = 1'b0;
		wn(12); `C("bright stop", 1'b1, seen)
		rs(7'h20);
		p;
		repeat (11) @(negedge core_clk);
		p;
		wn(12); `C("retrigger", 1'b0, seen)
		we;
		rs(7'h42);
		dark = 1'b0;
		p; `C("ext dusk", 1'b0, st)
		i_peer.lvl(1'b1);
		p; `C("ext lit", 1'b1, st)
		`C("ext deact", 1'b0, td)
		i_peer.lvl(1'b0);
		dark = 1'b1;
		we;
		test_done;
	end
endmodule // tb_top
